// ### logic/scsp_pkg.sv
package scsp_pkg;

  localparam int WORD_W = 24;
  localparam int SHORT_W = 16;
  localparam logic [4:0] LEN_LONG = 5'h18;
  localparam logic [4:0] LEN_SHORT = 5'h10;

  localparam int CLK_NS = 100;
  localparam int SCLK_HALF_NS = 400;
  localparam int SCLK_HALF_CYC_I = (SCLK_HALF_NS / CLK_NS < 1) ? 1 : SCLK_HALF_NS / CLK_NS;
  localparam logic [2:0] SCLK_HALF_LAST = 3'(SCLK_HALF_CYC_I - 1);

  localparam logic [23:0] CTRL_RESET = 24'h000000;
  localparam int CTRL_MODE_HI = 23;
  localparam int CTRL_MODE_LO = 21;
  localparam int CTRL_WL_BIT = 12;
  localparam logic [2:0] MODE_CAL_ZERO = 3'h6;
  localparam logic [2:0] MODE_CAL_FULL = 3'h7;

  localparam int PIN_N = 5;
  localparam int PIN_RD_FRAME = 0;
  localparam int PIN_WR_FRAME = 1;
  localparam int PIN_SEL = 2;
  localparam int PIN_SDI = 3;
  localparam int PIN_MODE = 4;
  localparam logic [4:0] PIN_IDLE = 5'h1F;

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} port_state_t;

  function automatic logic bits_match(input logic [4:0] a, input logic [4:0] b);
    return a == b;
  endfunction : bits_match

endpackage : scsp_pkg

// ### logic/pin_sync_if.sv
interface pin_sync_if;
  logic [scsp_pkg::PIN_N-1:0] lvl;
  logic [scsp_pkg::PIN_N-1:0] fall;
  modport syncer (output lvl, output fall);
  modport user (input lvl, input fall);
endinterface : pin_sync_if

// ### logic/pin_sync.sv
module pin_sync (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [scsp_pkg::PIN_N-1:0] raw,
  pin_sync_if.syncer sp
);

  logic [scsp_pkg::PIN_N-1:0] s1_r;
  logic [scsp_pkg::PIN_N-1:0] s2_r;
  logic [scsp_pkg::PIN_N-1:0] s3_r;
  logic [scsp_pkg::PIN_N-1:0] lvl_r;
  logic [scsp_pkg::PIN_N-1:0] fall_r;
  wire [scsp_pkg::PIN_N-1:0] agree = ~(s2_r ^ s3_r);
  wire [scsp_pkg::PIN_N-1:0] lvl_nxt = (s3_r & agree) | (lvl_r & ~agree);
  wire [scsp_pkg::PIN_N-1:0] fall_nxt = lvl_r & ~lvl_nxt;

  // A level counts only once the second and third stages agree.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r <= scsp_pkg::PIN_IDLE;
      s2_r <= scsp_pkg::PIN_IDLE;
      s3_r <= scsp_pkg::PIN_IDLE;
      lvl_r <= scsp_pkg::PIN_IDLE;
      fall_r <= '0;
    end else if (clk_en) begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
      fall_r <= fall_nxt;
    end
  end

  assign sp.lvl = lvl_r;
  assign sp.fall = fall_r;

endmodule : pin_sync

// ### logic/self_clocked_serial_port.sv
// Overview of operation
// - Reads reach output, control and calibration registers; writes reach control and calibration.
// - Two modes exist; this port serves the master mode, slave mode leaves it idle.
// - Mode pin high makes the port generate the serial clock for all transfers.
// - Select high reads output or calibration register, select low reads control register.
// - Ready goes low when a new word loads; only updates and output reads move it.
// - Ready returns high after the last bit, 16th or 24th by word length.
// - Unread words keep being replaced; ready stays low; a read returns the newest.
// - A word arriving during an output read is dropped and not signalled.
// - Control or calibration reads neither change ready nor depend on it.
// - Read frame falling while ready is high transfers no output data.
// - Read frame falling starts the serial clock and drives the MSB at once.
// - Later bits shift out on falling clock edges; last active fall gives the LSB.
// - The falling edge after the LSB returns ready high.
// - Ready rising switches off clock and data drivers at the fall that ends the LSB.
// - Reset loads the control register with its default state.
// - Write frame falling enables the clock; bits are taken on rising edges, MSB first.
module self_clocked_serial_port (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic mode_select,
  input wire logic read_frame_sync_n,
  input wire logic write_frame_sync_n,
  input wire logic register_select,
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe,
  output logic serial_clock_out,
  output logic serial_clock_oe,
  output logic conversion_ready_n,
  input wire logic new_word,
  input wire logic [23:0] conversion_word,
  input wire logic cal_load,
  input wire logic [23:0] zero_cal_in,
  input wire logic [23:0] full_cal_in,
  output logic [23:0] control_word,
  output logic [23:0] zero_cal_word,
  output logic [23:0] full_cal_word
);

  pin_sync_if sif ();

  pin_sync u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .raw({mode_select, serial_data_line_in, register_select, write_frame_sync_n,
          read_frame_sync_n}),
    .sp(sif.syncer)
  );

  scsp_pkg::port_state_t state_r;
  scsp_pkg::port_state_t state_nxt;
  logic sclk_r;
  logic sclk_oe_r;
  logic serial_data_line_oe_r;
  logic [2:0] half_cnt_r;
  logic [4:0] bit_cnt_r;
  logic [4:0] len_r;
  logic [23:0] shift_r;
  logic is_out_r;
  logic wr_sel_r;
  logic ready_n_r;
  logic [23:0] out_word_r;
  logic [23:0] ctrl_r;
  logic [23:0] zero_cal_r;
  logic [23:0] full_cal_r;

  wire [2:0] ctrl_mode = ctrl_r[scsp_pkg::CTRL_MODE_HI:scsp_pkg::CTRL_MODE_LO];
  wire cal_zero_sel = ctrl_mode == scsp_pkg::MODE_CAL_ZERO;
  wire cal_full_sel = ctrl_mode == scsp_pkg::MODE_CAL_FULL;
  wire cal_sel = cal_zero_sel | cal_full_sel;
  wire [23:0] cal_word = cal_full_sel ? full_cal_r : zero_cal_r;
  wire [4:0] out_len = ctrl_r[scsp_pkg::CTRL_WL_BIT] ? scsp_pkg::LEN_LONG : scsp_pkg::LEN_SHORT;
  wire sel_lvl = sif.lvl[scsp_pkg::PIN_SEL];
  wire idle = state_r == scsp_pkg::ST_IDLE;
  wire reading = state_r == scsp_pkg::ST_READ;
  wire writing = state_r == scsp_pkg::ST_WRITE;

  // Slave clock mode keeps this port quiet.
  wire self_mode = sif.lvl[scsp_pkg::PIN_MODE];
  wire rd_go = idle & self_mode & sif.fall[scsp_pkg::PIN_RD_FRAME];
  wire out_access = sel_lvl & ~cal_sel;
  // No output read while ready is high; control and calibration reads still run.
  wire rd_start = rd_go & ~(out_access & ready_n_r);
  // Writes go only to control or calibration.
  wire wr_start = idle & self_mode & sif.fall[scsp_pkg::PIN_WR_FRAME] & ~rd_go;
  wire [23:0] rd_word = ~sel_lvl ? ctrl_r : (cal_sel ? cal_word : out_word_r);
  wire [4:0] rd_len = out_access ? out_len : scsp_pkg::LEN_LONG;

  wire active = ~idle;
  wire half_done = half_cnt_r == scsp_pkg::SCLK_HALF_LAST;
  wire fall_tick = active & half_done & sclk_r;
  wire frame_end = fall_tick & scsp_pkg::bits_match(bit_cnt_r, len_r);
  // Shift on falling edges until the LSB.
  wire rd_shift = reading & fall_tick & ~frame_end;
  // Sample what stood through the rising edge, MSB first.
  wire wr_sample = writing & fall_tick & (bit_cnt_r != 5'h00);
  wire [23:0] wr_word = {shift_r[22:0], sif.lvl[scsp_pkg::PIN_SDI]};
  wire wr_commit = writing & frame_end;
  wire out_busy = reading & is_out_r;
  // Ready high on the fall after the LSB.
  wire ready_rise = frame_end & reading & is_out_r;

  // Frames start only from idle and return there on the last clock fall.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      scsp_pkg::ST_IDLE: begin
        if (rd_start) begin
          state_nxt = scsp_pkg::ST_READ;
        end else if (wr_start) begin
          state_nxt = scsp_pkg::ST_WRITE;
        end
      end
      scsp_pkg::ST_READ, scsp_pkg::ST_WRITE: begin
        if (frame_end) begin
          state_nxt = scsp_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = scsp_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= scsp_pkg::ST_IDLE;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // Write frame enables the clock too.
  // Frame end stops the clock driver.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_r <= 1'b1;
      sclk_oe_r <= 1'b0;
      half_cnt_r <= 3'h0;
    end else if (clk_en) begin
      if (rd_start | wr_start) begin
        sclk_r <= 1'b1;
        sclk_oe_r <= 1'b1;
        half_cnt_r <= 3'h0;
      end else if (frame_end) begin
        sclk_r <= 1'b1;
        sclk_oe_r <= 1'b0;
        half_cnt_r <= 3'h0;
      end else if (active) begin
        half_cnt_r <= half_done ? 3'h0 : half_cnt_r + 3'h1;
        sclk_r <= half_done ? ~sclk_r : sclk_r;
      end
    end
  end

  // MSB on the line at once.
  // Next bit on each falling edge.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_r <= 24'h000000;
      bit_cnt_r <= 5'h00;
      len_r <= scsp_pkg::LEN_LONG;
      is_out_r <= 1'b0;
      wr_sel_r <= 1'b0;
    end else if (clk_en) begin
      if (rd_start) begin
        shift_r <= rd_word;
        bit_cnt_r <= 5'h01;
        len_r <= rd_len;
        is_out_r <= out_access;
      end else if (wr_start) begin
        shift_r <= 24'h000000;
        bit_cnt_r <= 5'h00;
        len_r <= scsp_pkg::LEN_LONG;
        is_out_r <= 1'b0;
        wr_sel_r <= sel_lvl;
      end else if (rd_shift) begin
        shift_r <= {shift_r[22:0], 1'b0};
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end else if (writing & fall_tick) begin
        shift_r <= wr_sample ? wr_word : shift_r;
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end
    end
  end

  // Data driver off with ready rising.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_data_line_oe_r <= 1'b0;
    end else if (clk_en) begin
      serial_data_line_oe_r <= rd_start ? 1'b1 : (frame_end ? 1'b0 : serial_data_line_oe_r);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_n_r <= 1'b1;
      out_word_r <= 24'h000000;
    end else if (clk_en) begin
      if (new_word & ~out_busy) begin
        ready_n_r <= 1'b0;
        out_word_r <= conversion_word;
      end else if (ready_rise) begin
        ready_n_r <= 1'b1;
      end
    end
  end

  // Writes land in control or calibration.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= scsp_pkg::CTRL_RESET;
      zero_cal_r <= 24'h000000;
      full_cal_r <= 24'h000000;
    end else if (clk_en) begin
      if (wr_commit & ~wr_sel_r) begin
        ctrl_r <= wr_word;
      end
      if (wr_commit & wr_sel_r & ~cal_full_sel) begin
        zero_cal_r <= wr_word;
      end else if (cal_load) begin
        zero_cal_r <= zero_cal_in;
      end
      if (wr_commit & wr_sel_r & cal_full_sel) begin
        full_cal_r <= wr_word;
      end else if (cal_load) begin
        full_cal_r <= full_cal_in;
      end
    end
  end

  assign serial_data_line_out = shift_r[23];
  assign serial_data_line_oe = serial_data_line_oe_r;
  assign serial_clock_out = sclk_r;
  assign serial_clock_oe = sclk_oe_r;
  assign conversion_ready_n = ready_n_r;
  assign control_word = ctrl_r;
  assign zero_cal_word = zero_cal_r;
  assign full_cal_word = full_cal_r;

endmodule : self_clocked_serial_port

// ### bench/scsp_props.sv
module scsp_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic mode_select,
  input wire logic read_frame_sync_n,
  input wire logic new_word,
  input wire logic serial_data_line_out,
  input wire logic serial_data_line_oe,
  input wire logic serial_clock_out,
  input wire logic serial_clock_oe,
  input wire logic conversion_ready_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  a_start_msb: assert property (
    $rose(serial_data_line_oe) |-> serial_clock_oe && serial_clock_out) else $error("start");
  a_read_start: assert property (
    $fell(read_frame_sync_n) && mode_select && !serial_clock_oe && !conversion_ready_n
    |-> ##[3:7] serial_data_line_oe) else $error("read not started");
  a_clock_half: assert property (
    $fell(serial_clock_out) && serial_clock_oe |-> (!serial_clock_out)[*4] ##1 serial_clock_out)
    else $error("clock half period");
  a_data_on_fall: assert property (
    serial_data_line_oe && $past(serial_data_line_oe) && $changed(serial_data_line_out)
    |-> $fell(serial_clock_out)) else $error("data moved off a fall");
  a_ready_cause: assert property (
    $fell(conversion_ready_n) |-> $past(new_word)) else $error("ready fell alone");
  a_ready_end: assert property (
    $rose(conversion_ready_n) |-> $fell(serial_data_line_oe) && $fell(serial_clock_oe))
    else $error("ready rose off frame end");
  a_write_ready: assert property (
    serial_clock_oe && !serial_data_line_oe |=> !$rose(conversion_ready_n))
    else $error("write moved ready");
  a_mode_off: assert property (
    (!mode_select)[*6] |-> !$rose(serial_clock_oe)) else $error("frame in idle mode");
endmodule : scsp_props

bind self_clocked_serial_port scsp_props props_u (.clk, .reset_n, .mode_select,
  .read_frame_sync_n, .new_word, .serial_data_line_out, .serial_data_line_oe,
  .serial_clock_out, .serial_clock_oe, .conversion_ready_n);

// ### bench/scsp_host.sv
module scsp_host (
  input wire logic sck,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic rd_frame_n,
  input wire logic wr_frame_n,
  input wire logic [23:0] wdata,
  output logic sdi,
  output logic [23:0] rword,
  output int rcnt
);
  timeunit 1ns;
  timeprecision 1ns;
  int wcnt = 24;
  initial sdi = 1'b0;
  // next bit after each fall; toggles once the word is spent.
  always @(negedge wr_frame_n or negedge sck) begin
    if (sck === 1'b1) begin
      wcnt = 0;
    end else begin
      sdi <= (wcnt < 24) ? wdata[23 - wcnt] : ~sdi;
      wcnt = wcnt + 1;
    end
  end
  // MSB taken at drive start, later bits on rises.
  always @(negedge rd_frame_n or posedge sck or posedge sdo_oe) begin
    #1;
    if (sdo_oe === 1'b1) begin
      rword = {rword[22:0], sdo};
      rcnt = rcnt + 1;
    end else if (rd_frame_n === 1'b0) begin
      rword = 24'h000000;
      rcnt = 0;
    end
  end
endmodule : scsp_host

// ### bench/tb_self_clocked_serial_port.sv
module tb_self_clocked_serial_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic mode_select = 1'b1;
  logic read_frame_sync_n = 1'b1;
  logic write_frame_sync_n = 1'b1;
  logic register_select = 1'b0;
  logic new_word = 1'b0;
  logic cal_load = 1'b0;
  logic [23:0] conversion_word = 24'h000000;
  logic [23:0] zero_cal_in = 24'h0F1E2D;
  logic [23:0] full_cal_in = 24'h3C3C3C;
  logic [23:0] wdata = 24'h000000;
  logic serial_data_line_in, serial_data_line_out, serial_data_line_oe;
  logic serial_clock_out, serial_clock_oe, conversion_ready_n;
  logic [23:0] control_word, zero_cal_word, full_cal_word, rword;
  int rcnt;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  // The clock line has a pull-up.
  wire logic sck = serial_clock_oe ? serial_clock_out : 1'b1;
  self_clocked_serial_port dut_u (.clk, .reset_n, .clk_en(1'b1), .mode_select,
    .read_frame_sync_n, .write_frame_sync_n, .register_select, .serial_data_line_in,
    .serial_data_line_out, .serial_data_line_oe, .serial_clock_out, .serial_clock_oe,
    .conversion_ready_n, .new_word, .conversion_word, .cal_load, .zero_cal_in,
    .full_cal_in, .control_word, .zero_cal_word, .full_cal_word);
  scsp_host host_u (.sck, .sdo(serial_data_line_out), .sdo_oe(serial_data_line_oe),
    .rd_frame_n(read_frame_sync_n), .wr_frame_n(write_frame_sync_n), .wdata,
    .sdi(serial_data_line_in), .rword, .rcnt);
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      conclude();
    end
  end
  task automatic conclude();
    if (errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_flag(input logic got, input logic exp);
    chk({23'h000000, got}, {23'h000000, exp});
  endtask : chk_flag
  task automatic xfer(input logic rd, input logic sel, input logic [23:0] d);
    int i;
    @(negedge clk);
    wdata = d;
    register_select = sel;
    if (rd) read_frame_sync_n = 1'b0;
    else write_frame_sync_n = 1'b0;
    for (i = 0; i < 40 && serial_clock_oe !== 1'b1; i++) @(negedge clk);
    for (i = 0; i < 300 && serial_clock_oe === 1'b1; i++) @(negedge clk);
    read_frame_sync_n = 1'b1;
    write_frame_sync_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask : xfer
  task automatic word(input logic [23:0] w);
    @(negedge clk);
    conversion_word = w;
    new_word = 1'b1;
    @(negedge clk);
    new_word = 1'b0;
  endtask : word
  task automatic t_reset();
    chk(control_word, 24'h000000);
    chk_flag(serial_clock_oe | serial_data_line_oe, 1'b0);
    chk_flag(conversion_ready_n, 1'b1);
  endtask : t_reset
  task automatic t_write();
    xfer(1'b0, 1'b0, 24'h001000);
    chk(control_word, 24'h001000);
    xfer(1'b0, 1'b1, 24'hA5C3E1);
    chk(zero_cal_word, 24'hA5C3E1);
    chk_flag(conversion_ready_n, 1'b1);
  endtask : t_write
  task automatic t_ctrl_read();
    xfer(1'b1, 1'b0, 24'h000000);
    chk(rcnt, 24'h000018);
    chk(rword, 24'h001000);
  endtask : t_ctrl_read
  task automatic t_refused();
    xfer(1'b1, 1'b1, 24'h000000);
    chk(rcnt, 24'h000000);
    mode_select = 1'b0;
    repeat (8) @(negedge clk);
    xfer(1'b1, 1'b0, 24'h000000);
    chk(rcnt, 24'h000000);
    mode_select = 1'b1;
    repeat (8) @(negedge clk);
  endtask : t_refused
  task automatic t_out24();
    word(24'h123456);
    word(24'h89ABCD);
    chk_flag(conversion_ready_n, 1'b0);
    xfer(1'b1, 1'b0, 24'h000000);
    chk_flag(conversion_ready_n, 1'b0);
    fork
      xfer(1'b1, 1'b1, 24'h000000);
      begin
        repeat (60) @(negedge clk);
        word(24'h777777);
      end
    join
    chk(rword, 24'h89ABCD);
    chk(rcnt, 24'h000018);
    chk_flag(conversion_ready_n, 1'b1);
  endtask : t_out24
  task automatic t_out16();
    xfer(1'b0, 1'b0, 24'h000000);
    word(24'hFEDCBA);
    xfer(1'b1, 1'b1, 24'h000000);
    chk(rcnt, 24'h000010);
    chk(rword, 24'h00FEDC);
    chk_flag(conversion_ready_n, 1'b1);
  endtask : t_out16
  task automatic t_cal();
    @(negedge clk);
    cal_load = 1'b1;
    @(negedge clk);
    cal_load = 1'b0;
    chk(full_cal_word, 24'h3C3C3C);
    xfer(1'b0, 1'b0, 24'hE00000);
    xfer(1'b1, 1'b1, 24'h000000);
    chk(rword, 24'h3C3C3C);
    xfer(1'b0, 1'b1, 24'h5A5A5A);
    chk(full_cal_word, 24'h5A5A5A);
    xfer(1'b0, 1'b0, 24'hC00000);
    xfer(1'b1, 1'b1, 24'h000000);
    chk(rword, 24'h0F1E2D);
  endtask : t_cal
  initial begin
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    t_reset();
    t_write();
    t_ctrl_read();
    t_refused();
    t_out24();
    t_out16();
    t_cal();
    conclude();
  end
endmodule : tb_self_clocked_serial_port
